// ==== src/slpc_pkg.sv ====
package slpc_pkg;

    // Register map
    localparam logic [7:0] SLPC_ADDR_CTRL       = 8'h00;
    localparam logic [7:0] SLPC_ADDR_STATUS     = 8'h01;
    localparam logic [7:0] SLPC_CTRL_RESET      = 8'h00;
    localparam int         SLPC_ARM_BIT         = 0;
    localparam int         SLPC_MODE_LSB        = 1;
    localparam int         SLPC_MODE_MSB        = 2;

    // Sleep mode select encodings
    localparam logic [1:0] SLPC_MODE_IDLE       = 2'h0;
    localparam logic [1:0] SLPC_MODE_STANDBY    = 2'h1;
    localparam logic [1:0] SLPC_MODE_DEEP       = 2'h2;

    // Brown-out active-mode fuse value that asks for a ready wait
    localparam logic [1:0] SLPC_BOD_WAIT_CFG    = 2'h3;

    // Wake-up latency in reference clock cycles
    localparam int         SLPC_WAKE_CYCLES     = 6;
    localparam logic [3:0] SLPC_WAKE_CNT_RESET  = 4'h0;

    // Wake source indices
    localparam int         SLPC_NSRC            = 9;
    localparam int         SLPC_SRC_PIN         = 0;
    localparam int         SLPC_SRC_TWI_MATCH   = 1;
    localparam int         SLPC_SRC_VLM         = 2;
    localparam int         SLPC_SRC_LOGIC       = 3;
    localparam int         SLPC_SRC_RTC_CNT     = 4;
    localparam int         SLPC_SRC_PERIODIC    = 5;
    localparam int         SLPC_SRC_SERIAL_SOF  = 6;
    localparam int         SLPC_SRC_TIMER_A     = 7;
    localparam int         SLPC_SRC_OTHER       = 8;

    // Number of configurable logic lookup tables
    localparam int         SLPC_NLUT            = 4;

    typedef enum logic [1:0] {
        SLPC_ST_ACTIVE,
        SLPC_ST_SLEEP,
        SLPC_ST_OSC_WAIT,
        SLPC_ST_WAKE
    } slpc_state_e;

endpackage

// ==== src/slpc_wake_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface slpc_wake_if;
    logic [1:0] mode;
    logic       asleep;
    logic [8:0] src_req;
    logic [8:0] src_stby;
    logic       wake;

    modport ctrl (output mode, output asleep, output src_req,
                  output src_stby, input wake);
    modport filt (input mode, input asleep, input src_req,
                  input src_stby, output wake);
endinterface
`default_nettype wire

// ==== src/slpc_wake_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
module slpc_wake_filter
(
    // Wake qualification
    slpc_wake_if.filt w
);
    import slpc_pkg::*;

    logic [SLPC_NSRC-1:0] allow;

    always_comb
    begin
        allow = '0;
        case (w.mode)
            SLPC_MODE_STANDBY:
            begin
                allow[SLPC_SRC_PIN]       = 1'b1;
                allow[SLPC_SRC_TWI_MATCH] = 1'b1;
                allow[SLPC_SRC_VLM]       = 1'b1;
                allow[SLPC_SRC_SERIAL_SOF] = 1'b1;
                // Gated by their run-in-standby settings
                allow[SLPC_SRC_LOGIC]    = w.src_stby[SLPC_SRC_LOGIC];
                allow[SLPC_SRC_RTC_CNT]  = w.src_stby[SLPC_SRC_RTC_CNT];
                allow[SLPC_SRC_PERIODIC] = w.src_stby[SLPC_SRC_PERIODIC];
                allow[SLPC_SRC_TIMER_A]  = w.src_stby[SLPC_SRC_TIMER_A];
            end
            SLPC_MODE_DEEP:
            begin
                allow[SLPC_SRC_PIN]       = 1'b1;
                allow[SLPC_SRC_TWI_MATCH] = 1'b1;
                allow[SLPC_SRC_VLM]       = 1'b1;
                allow[SLPC_SRC_LOGIC]     = 1'b1;
                allow[SLPC_SRC_PERIODIC]  = 1'b1;
            end
            default:
            begin
                allow = '1;
            end
        endcase
    end

    assign w.wake = w.asleep && |(allow & w.src_req);
endmodule
`default_nettype wire

// ==== src/slpc_sleep_controller.sv ====
`timescale 1ns/1ns
`default_nettype none
module slpc_sleep_controller
(
    // Clock and reset
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rst_b,
    // Register port
    input  wire logic [7:0]                   i_addr,
    input  wire logic [7:0]                   i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [7:0]                   o_rdata,
    // CPU side
    input  wire logic                         i_sleep_instr,
    input  wire logic                         i_debug_break,
    output logic                              o_cpu_halt,
    output logic                              o_wake_irq,
    // Wake request sources, peripheral standby settings
    input  wire logic [slpc_pkg::SLPC_NSRC-1:0] i_wake_src,
    input  wire logic [slpc_pkg::SLPC_NSRC-1:0] i_src_run_in_standby,
    input  wire logic [slpc_pkg::SLPC_NLUT-1:0] i_lut_irq,
    input  wire logic [slpc_pkg::SLPC_NLUT-1:0] i_lut_async,
    // Clock controller and brownout detector
    input  wire logic                         i_osc_ready,
    input  wire logic                         i_brownout_ready,
    input  wire logic [1:0]                   i_brownout_config_fuse,
    input  wire logic                         i_main_clk_needed,
    output logic                              o_main_clk_en,
    output logic                              o_periph_clk_en,
    output logic                              o_rtc_count_en,
    output logic                              o_periodic_tick_en,
    output logic                              o_logic_clk_en,
    output logic                              o_always_on_en
);
    import slpc_pkg::*;

    logic                 sleep_arm_bit;
    logic [1:0]           sleep_mode_select;
    logic [1:0]           active_mode;
    slpc_state_e          state;
    logic [3:0]           wake_cnt;
    logic [SLPC_NSRC-1:0] src_sync1;
    logic [SLPC_NSRC-1:0] src_sync2;
    logic [SLPC_NLUT-1:0] lut_sync1;
    logic [SLPC_NLUT-1:0] lut_sync2;
    logic [2:0]           misc_sync1;
    logic [2:0]           misc_sync2;
    logic                 dbg_now;
    logic                 osc_rdy;
    logic                 bod_rdy;
    logic [SLPC_NSRC-1:0] src_eff;
    logic                 asleep;
    logic                 wake_event;
    logic                 wake_done;
    logic                 bod_hold;
    logic [1:0]           next_mode;

    slpc_wake_if wif ();

    slpc_wake_filter u_filter
    (
        .w (wif.filt)
    );

    // Two-flop synchronisers for all pin-level inputs
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            src_sync1  <= '0;
            src_sync2  <= '0;
            lut_sync1  <= '0;
            lut_sync2  <= '0;
            misc_sync1 <= '0;
            misc_sync2 <= '0;
        end
        else
        begin
            src_sync1  <= i_wake_src;
            src_sync2  <= src_sync1;
            lut_sync1  <= i_lut_irq;
            lut_sync2  <= lut_sync1;
            misc_sync1 <= {i_debug_break, i_osc_ready, i_brownout_ready};
            misc_sync2 <= misc_sync1;
        end
    end

    assign dbg_now = misc_sync2[2];
    assign osc_rdy = misc_sync2[1];
    assign bod_rdy = misc_sync2[0];

    // Outside idle, the logic source wakes only through asynchronous lookup-table paths
    always_comb
    begin
        src_eff = src_sync2;
        if (active_mode != SLPC_MODE_IDLE)
        begin
            // Path setting is static; only the request itself is synced
            src_eff[SLPC_SRC_LOGIC] = |(lut_sync2 & i_lut_async);
        end
    end

    assign asleep       = (state == SLPC_ST_SLEEP);
    assign wif.mode     = active_mode;
    assign wif.asleep   = asleep;
    assign wif.src_req  = src_eff;
    assign wif.src_stby = i_src_run_in_standby;
    assign wake_event   = wif.wake;

    // Reserved encodings fall back to idle
    assign next_mode = (sleep_mode_select == SLPC_MODE_STANDBY ||
                        sleep_mode_select == SLPC_MODE_DEEP)
                       ? sleep_mode_select : SLPC_MODE_IDLE;

    // Control register: contents survive sleep
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sleep_arm_bit     <= SLPC_CTRL_RESET[SLPC_ARM_BIT];
            sleep_mode_select <= SLPC_CTRL_RESET[SLPC_MODE_MSB:SLPC_MODE_LSB];
        end
        else if (i_wr && i_addr == SLPC_ADDR_CTRL)
        begin
            sleep_arm_bit     <= i_wdata[SLPC_ARM_BIT];
            sleep_mode_select <= i_wdata[SLPC_MODE_MSB:SLPC_MODE_LSB];
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                SLPC_ADDR_CTRL:
                    o_rdata <= {5'h00, sleep_mode_select, sleep_arm_bit};
                SLPC_ADDR_STATUS:
                    o_rdata <= {4'h0, active_mode, state};
                default:
                    o_rdata <= 8'h00;
            endcase
        end
        else
        begin
            o_rdata <= 8'h00;
        end
    end

    assign wake_done = (wake_cnt == 4'(SLPC_WAKE_CYCLES - 1));
    assign bod_hold  = (i_brownout_config_fuse == SLPC_BOD_WAIT_CFG)
                       && !bod_rdy;

    // Sleep sequencer; a system reset always lands in active
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state       <= SLPC_ST_ACTIVE;
            active_mode <= SLPC_MODE_IDLE;
        end
        else
        begin
            case (state)
                SLPC_ST_ACTIVE:
                begin
                    if (i_sleep_instr && sleep_arm_bit)
                    begin
                        state       <= SLPC_ST_SLEEP;
                        active_mode <= next_mode;
                    end
                end
                SLPC_ST_SLEEP:
                begin
                    if (wake_event || dbg_now)
                    begin
                        if (active_mode == SLPC_MODE_IDLE)
                            state <= SLPC_ST_WAKE;
                        else
                            state <= SLPC_ST_OSC_WAIT;
                    end
                end
                SLPC_ST_OSC_WAIT:
                begin
                    if (osc_rdy)
                        state <= SLPC_ST_WAKE;
                end
                SLPC_ST_WAKE:
                begin
                    if (wake_done && !bod_hold)
                        state <= SLPC_ST_ACTIVE;
                end
                default:
                begin
                    state <= SLPC_ST_ACTIVE;
                end
            endcase
        end
    end

    // Wake latency counter
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            wake_cnt <= SLPC_WAKE_CNT_RESET;
        else if (state != SLPC_ST_WAKE)
            wake_cnt <= SLPC_WAKE_CNT_RESET;
        else if (!wake_done)
            wake_cnt <= wake_cnt + 4'h1;
    end

    // Handler request on interrupt wake; CPU resumes after the sleep op
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_wake_irq <= 1'b0;
        else
            o_wake_irq <= asleep && wake_event;
    end

    // Clock and peripheral gating per mode
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_cpu_halt         <= 1'b0;
            o_main_clk_en      <= 1'b1;
            o_periph_clk_en    <= 1'b1;
            o_rtc_count_en     <= 1'b1;
            o_periodic_tick_en <= 1'b1;
            o_logic_clk_en     <= 1'b1;
            o_always_on_en     <= 1'b1;
        end
        else
        begin
            o_always_on_en <= 1'b1;
            if (state == SLPC_ST_ACTIVE)
            begin
                o_cpu_halt         <= 1'b0;
                o_main_clk_en      <= 1'b1;
                o_periph_clk_en    <= 1'b1;
                o_rtc_count_en     <= 1'b1;
                o_periodic_tick_en <= 1'b1;
                o_logic_clk_en     <= 1'b1;
            end
            else if (state != SLPC_ST_SLEEP)
            begin
                // Waking: clocks back on, CPU still held
                o_cpu_halt         <= 1'b1;
                o_main_clk_en      <= 1'b1;
                o_periph_clk_en    <= 1'b1;
                o_rtc_count_en     <= 1'b1;
                o_periodic_tick_en <= 1'b1;
                o_logic_clk_en     <= 1'b1;
            end
            else
            begin
                o_cpu_halt <= 1'b1;
                case (active_mode)
                    SLPC_MODE_STANDBY:
                    begin
                        o_main_clk_en   <= i_main_clk_needed;
                        o_periph_clk_en <= 1'b0;
                        o_rtc_count_en  <=
                            i_src_run_in_standby[SLPC_SRC_RTC_CNT];
                        o_periodic_tick_en <=
                            i_src_run_in_standby[SLPC_SRC_PERIODIC];
                        o_logic_clk_en  <=
                            i_src_run_in_standby[SLPC_SRC_LOGIC];
                    end
                    SLPC_MODE_DEEP:
                    begin
                        o_main_clk_en      <= 1'b0;
                        o_periph_clk_en    <= 1'b0;
                        o_rtc_count_en     <= 1'b0;
                        o_periodic_tick_en <= 1'b1;
                        o_logic_clk_en     <= 1'b0;
                    end
                    default:
                    begin
                        o_main_clk_en      <= 1'b1;
                        o_periph_clk_en    <= 1'b1;
                        o_rtc_count_en     <= 1'b1;
                        o_periodic_tick_en <= 1'b1;
                        o_logic_clk_en     <= 1'b1;
                    end
                endcase
            end
        end
    end

    sequence s_wake_done;
        state == SLPC_ST_WAKE && wake_done && !bod_hold;
    endsequence

    a_unarmed_stays: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (state == SLPC_ST_ACTIVE && i_sleep_instr && !sleep_arm_bit)
        |=> state == SLPC_ST_ACTIVE)
        else $error("sleep entered while unarmed");

    a_idle_wake_time: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (asleep && wake_event && active_mode == SLPC_MODE_IDLE
         && i_brownout_config_fuse != SLPC_BOD_WAIT_CFG)
        |=> (state == SLPC_ST_WAKE)[*6] ##1 state == SLPC_ST_ACTIVE)
        else $error("idle wake not six cycles");

    a_bod_holds_exec: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (state == SLPC_ST_WAKE && bod_hold) |=> state != SLPC_ST_ACTIVE)
        else $error("execution before brownout ready");

    a_debug_wakes: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (asleep && dbg_now) |=> !asleep)
        else $error("debug break ignored in sleep");

    a_deep_main_off: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (asleep && active_mode == SLPC_MODE_DEEP) |=> !o_main_clk_en)
        else $error("main clock on in deep sleep");

    a_deep_no_timer: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (active_mode == SLPC_MODE_DEEP && src_eff == (SLPC_NSRC'(1)
         << SLPC_SRC_TIMER_A)) |-> !wake_event)
        else $error("timer woke deep sleep");

    a_reserved_idle: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (state == SLPC_ST_ACTIVE && i_sleep_instr && sleep_arm_bit
         && sleep_mode_select == 2'h3) |=> active_mode == SLPC_MODE_IDLE)
        else $error("reserved mode not idle");

    a_sleep_halts: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        asleep |=> o_cpu_halt)
        else $error("cpu running while asleep");

    a_resume_active: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        s_wake_done |=> state == SLPC_ST_ACTIVE ##1 !o_cpu_halt)
        else $error("no resume after wake");
endmodule
`default_nettype wire

// ==== verif/slpc_clk_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
module slpc_clk_partner
#(
    parameter int OSC_DLY = 12,
    parameter int BOD_DLY = 40
)
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    // Demand seen by the clock controller
    input  wire logic i_main_clk_en,
    input  wire logic i_wake_any,
    // Readiness back to the sleep controller
    output logic      o_osc_ready,
    output logic      o_bod_ready
);
    int   osc_cnt;
    int   bod_cnt;
    logic run;

    // A pending wake request restarts the oscillator before any enable
    assign run = i_main_clk_en | i_wake_any;

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            osc_cnt <= OSC_DLY;
            bod_cnt <= BOD_DLY;
        end
        else if (!run)
        begin
            osc_cnt <= 0;
            bod_cnt <= 0;
        end
        else
        begin
            if (osc_cnt < OSC_DLY)
                osc_cnt <= osc_cnt + 1;
            if (bod_cnt < BOD_DLY)
                bod_cnt <= bod_cnt + 1;
        end
    end

    assign o_osc_ready = (osc_cnt >= OSC_DLY);
    // Sampled brownout detector stops with the main clock, slow to return
    assign o_bod_ready = (bod_cnt >= BOD_DLY);
endmodule
`default_nettype wire

// ==== verif/sleep_mode_controller_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module sleep_mode_controller_bench;
    import slpc_pkg::*;
    localparam int OSC_DLY = 12;
    localparam int BOD_DLY = 40;
    logic                 i_ref_clk;
    logic                 i_rst_b;
    logic [7:0]           i_addr;
    logic [7:0]           i_wdata;
    logic                 i_wr;
    logic                 i_rd;
    logic [7:0]           o_rdata;
    logic                 i_sleep_instr;
    logic                 i_debug_break;
    logic                 o_cpu_halt;
    logic                 o_wake_irq;
    logic [SLPC_NSRC-1:0] i_wake_src;
    logic [SLPC_NSRC-1:0] i_src_run_in_standby;
    logic [SLPC_NLUT-1:0] i_lut_irq;
    logic [SLPC_NLUT-1:0] i_lut_async;
    logic                 i_osc_ready;
    logic                 i_brownout_ready;
    logic [1:0]           i_brownout_config_fuse;
    logic                 i_main_clk_needed;
    logic [5:0]           en;
    logic                 wake_any;
    logic [7:0]           d;
    int                   num_errors;
    int                   num_checks;
    int                   irq_cnt;
    int                   lat;
    bit                   woke;

    assign wake_any = (|i_wake_src) | (|i_lut_irq) | i_debug_break;

    slpc_sleep_controller slpc_sleep_controller_inst (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sleep_instr(i_sleep_instr), .i_debug_break(i_debug_break),
        .o_cpu_halt(o_cpu_halt), .o_wake_irq(o_wake_irq),
        .i_wake_src(i_wake_src),
        .i_src_run_in_standby(i_src_run_in_standby),
        .i_lut_irq(i_lut_irq), .i_lut_async(i_lut_async),
        .i_osc_ready(i_osc_ready), .i_brownout_ready(i_brownout_ready),
        .i_brownout_config_fuse(i_brownout_config_fuse),
        .i_main_clk_needed(i_main_clk_needed),
        .o_main_clk_en(en[5]), .o_periph_clk_en(en[4]),
        .o_rtc_count_en(en[3]), .o_periodic_tick_en(en[2]),
        .o_logic_clk_en(en[1]), .o_always_on_en(en[0]));

    slpc_clk_partner #(.OSC_DLY(OSC_DLY), .BOD_DLY(BOD_DLY))
        slpc_clk_partner_inst (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_main_clk_en(en[5]),
        .i_wake_any(wake_any), .o_osc_ready(i_osc_ready),
        .o_bod_ready(i_brownout_ready));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk)
        if (o_wake_irq === 1'b1)
            irq_cnt++;

    task automatic chk_val(input string w, input logic [7:0] e,
                           input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask

    task automatic chk_lat(input string w, input int lo, input int hi,
                           input int g);
        num_checks++;
        if (g < lo || g > hi)
        begin
            num_errors++;
            $display("unexpected %s: expected %0d..%0d seen %0d", w, lo, hi, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    task automatic sleep_pulse();
        @(posedge i_ref_clk);
        i_sleep_instr <= 1'b1;
        @(posedge i_ref_clk);
        i_sleep_instr <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wait_wake(output int n);
        n = 0;
        while (n < 120 && o_cpu_halt !== 1'b0)
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
    endtask

    function automatic logic [7:0] exp_en(input logic [1:0] m);
        if (m == SLPC_MODE_DEEP)
            return 8'h05;
        if (m == SLPC_MODE_STANDBY)
            return {2'h0, i_main_clk_needed, 1'b0,
                    i_src_run_in_standby[SLPC_SRC_RTC_CNT],
                    i_src_run_in_standby[SLPC_SRC_PERIODIC],
                    i_src_run_in_standby[SLPC_SRC_LOGIC], 1'b1};
        return 8'h3f;
    endfunction

    function automatic bit allowed(input int m, input int s);
        bit rs;
        rs = i_src_run_in_standby[s];
        if (m == 0 || m == 3)
            return 1'b1;
        if (s == SLPC_SRC_LOGIC)
            return i_lut_async[1] && (m == 2 || rs);
        if (m == 1)
            return (s < 3 || s == SLPC_SRC_SERIAL_SOF) ||
                   (s != SLPC_SRC_OTHER && rs);
        return s < 3 || s == SLPC_SRC_PERIODIC;
    endfunction

    task automatic nap(input logic [1:0] m, input int s, output int n,
                       output bit ok);
        int         irq0;
        int         dl;
        logic [7:0] st;
        reg_wr(SLPC_ADDR_CTRL, {5'h0, m, 1'b1});
        sleep_pulse();
        chk_val("halt asleep", 8'h01, {7'h0, o_cpu_halt});
        chk_val("enables", exp_en(m), {2'h0, en});
        reg_rd(SLPC_ADDR_STATUS, st);
        chk_val("status", {4'h0, (m == 2'h3) ? 2'h0 : m, 2'h1}, st);
        irq0 = irq_cnt;
        @(posedge i_ref_clk);
        // Source already enabled and sensing asynchronously
        i_wake_src[s] <= 1'b1;
        if (s == SLPC_SRC_LOGIC)
            i_lut_irq[1] <= 1'b1;
        wait_wake(n);
        ok = (o_cpu_halt === 1'b0);
        chk_val("wake irq", {7'h0, ok}, 8'(irq_cnt - irq0));
        @(posedge i_ref_clk);
        i_wake_src <= '0;
        i_lut_irq <= '0;
        if (!ok)
        begin
            i_debug_break <= 1'b1;
            wait_wake(dl);
            chk_val("debug wake", 8'h00, {7'h0, o_cpu_halt});
            chk_val("debug irq", 8'h00, 8'(irq_cnt - irq0));
            if (o_cpu_halt !== 1'b0)
                tally_and_finish();
            @(posedge i_ref_clk);
            i_debug_break <= 1'b0;
        end
        repeat (4) @(posedge i_ref_clk);
    endtask

    initial
    begin
        {i_rst_b, i_wr, i_rd, i_sleep_instr, i_debug_break} = '0;
        {i_addr, i_wdata, i_wake_src, i_lut_irq} = '0;
        {i_src_run_in_standby, i_lut_async, i_main_clk_needed} = '0;
        i_brownout_config_fuse = 2'h0;
        num_errors = 0;
        num_checks = 0;
        irq_cnt = 0;
        void'($urandom(16138));
        repeat (4) @(posedge i_ref_clk);
        #1;
        chk_val("enables in reset", 8'h3f, {2'h0, en});
        @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        reg_rd(SLPC_ADDR_CTRL, d);
        chk_val("control reset", SLPC_CTRL_RESET, d);
        reg_wr(SLPC_ADDR_CTRL, 8'hff);
        reg_rd(SLPC_ADDR_CTRL, d);
        chk_val("control bits", 8'h07, d);
        reg_rd(8'h05, d);
        chk_val("unmapped read", 8'h00, d);
        reg_wr(SLPC_ADDR_CTRL, 8'h04);
        sleep_pulse();
        chk_val("unarmed halt", 8'h00, {7'h0, o_cpu_halt});
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < SLPC_NSRC; s++)
            begin
                @(posedge i_ref_clk);
                i_src_run_in_standby <= 9'($urandom());
                i_lut_async <= 4'($urandom());
                i_main_clk_needed <= 1'($urandom());
                @(posedge i_ref_clk);
                nap(2'(m), s, lat, woke);
                chk_val("woke", {7'h0, allowed(m, s)}, {7'h0, woke});
                if (m % 3 == 0 && s == 0)
                    chk_lat("idle latency", 10, 10, lat);
            end
        @(posedge i_ref_clk);
        i_main_clk_needed <= 1'b0;
        i_brownout_config_fuse <= 2'h3;
        nap(SLPC_MODE_STANDBY, SLPC_SRC_PIN, lat, woke);
        chk_lat("brownout wait", BOD_DLY, BOD_DLY + 14, lat);
        @(posedge i_ref_clk);
        i_brownout_config_fuse <= 2'h0;
        nap(SLPC_MODE_DEEP, SLPC_SRC_PIN, lat, woke);
        chk_lat("oscillator wait", OSC_DLY + 6, OSC_DLY + 14, lat);
        reg_rd(SLPC_ADDR_CTRL, d);
        chk_val("control kept", 8'h05, d);
        sleep_pulse();
        @(posedge i_ref_clk);
        i_rst_b <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        chk_val("halt in reset", 8'h00, {7'h0, o_cpu_halt});
        @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        reg_rd(SLPC_ADDR_CTRL, d);
        chk_val("control after reset", 8'h00, d);
        tally_and_finish();
    end

    initial
    begin
        repeat (100000) @(posedge i_ref_clk);
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
